// ==== core/cfg_lock_pkg.sv ====
package cfg_lock_pkg;

    // ********************************
    // register indexes
    // ********************************
    localparam logic [7:0] IDX_FAMILY_IDENTITY = 8'h20;
    localparam logic [7:0] IDX_SERVER_CONFIG_ONE = 8'h21;
    localparam logic [7:0] IDX_SERVER_CONFIG_TWO = 8'h22;
    localparam logic [7:0] IDX_SERVER_CONFIG_THREE = 8'h23;
    localparam logic [7:0] IDX_SERVER_CONFIG_FOUR = 8'h24;
    localparam logic [7:0] IDX_SERVER_CONFIG_FIVE = 8'h25;
    localparam logic [7:0] IDX_SERVER_CONFIG_SIX = 8'h26;
    localparam logic [7:0] IDX_REVISION_IDENTITY = 8'h27;
    localparam logic [7:0] IDX_SERVER_CONFIG_EIGHT = 8'h28;
    localparam logic [7:0] IDX_CLOCK_GENERATOR_CONFIG = 8'h29;
    localparam logic [7:0] IDX_SERIAL_BUS_CONFIG = 8'h2A;
    localparam logic [7:0] IDX_DECODE_LAST = 8'h2E;
    // sleep / timer / ram lock block indexes (same local index space)
    localparam logic [7:0] IDX_POWER_TIMER_CONTROL = 8'h30;
    localparam logic [7:0] IDX_SLEEP_STATE_CONFIG = 8'h31;
    localparam logic [7:0] IDX_STATE0_SLEEP_TYPE = 8'h32;
    localparam logic [7:0] IDX_STATE5_SLEEP_TYPE = 8'h37;
    localparam logic [7:0] IDX_RAM_LOCK_REGISTER = 8'h38;
    localparam logic [7:0] IDX_RAM_ACCESS_CONTROL = 8'h39;

    // ********************************
    // identity values (arbitrary)
    // ********************************
    localparam logic [7:0] FAMILY_ID_VALUE = 8'h5A;
    localparam logic [7:0] REVISION_ID_VALUE = 8'h01;

    // ********************************
    // field positions
    // ********************************
    localparam int CF1_MUX_LOCK_BIT = 7;
    localparam int CF1_GPIO_LOCK_BIT = 6;
    localparam int CF1_WAIT_LSB = 2;
    localparam int CF1_SOFT_RESET_BIT = 1;
    localparam int CF1_ENABLE_BIT = 0;
    localparam int TIMER_LOCK_BIT = 7;
    localparam int SLEEP_LOCK_BIT = 7;
    localparam int RAM_LOCK_BITS = 5;
    localparam int RAM_UNLOCK_SEEN_BIT = 7;
    localparam int SLEEP_TYPE_REGS = 6;

    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] CF1_RESET = 8'h11;
    localparam logic [1:0] CF1_RSVD_VALUE = 2'h1;
    localparam logic [7:0] CF2_RESET = 8'h20;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // wait-state encodings
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [3:0] WAIT_CNT_NONE = 4'h0;
    localparam logic [3:0] WAIT_CNT_TWO = 4'h2;
    localparam logic [3:0] WAIT_CNT_SIX = 4'h6;
    localparam logic [3:0] WAIT_CNT_TWELVE = 4'hC;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic wake_control_unlock;
        logic ram_unlock;
        logic multiplex_unlock;
        logic gpio_unlock;
        logic standby_lock_select;
    } serial_lock_control_t;

    typedef struct packed {
        logic [7:0] server_config_one;
        logic [7:0] server_config_two;
        logic [7:0] server_config_three;
        logic [7:0] server_config_four;
        logic [7:0] server_config_five;
        logic [7:0] server_config_six;
        logic [7:0] server_config_eight;
        logic [7:0] clock_generator_config;
        logic [7:0] serial_bus_config;
        logic [7:0] power_timer_control;
        logic [7:0] sleep_state_config;
        logic [SLEEP_TYPE_REGS*8-1:0] sleep_types;
        logic [7:0] ram_lock_register;
        logic [7:0] ram_access_control;
        logic [7:0] rdata;
        logic rvalid;
        logic soft_reset_pulse;
        logic [3:0] wait_count;
    } bank_state_t;

endpackage : cfg_lock_pkg

// ==== core/lock_bit_cell.sv ====
`timescale 1ns/100ps
// sticky write-one-to-set lock: host sets, unlock pulse or selected reset clears
module lock_bit_cell
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // selected power-up clear and control
    input wire logic clear_i,
    input wire logic set_i,
    input wire logic unlock_i,
    // state
    output logic lock_o
);
    logic lock_q;
    logic lock_d;

    always_comb
    begin
        lock_d = lock_q;
        if (set_i)
        begin
            lock_d = 1'b1;
        end
        // unlock wins: it is the management controller's override
        if (unlock_i || clear_i)
        begin
            lock_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            lock_q <= 1'b0;
        end
        else
        begin
            lock_q <= lock_d;
        end
    end

    assign lock_o = lock_q;
endmodule : lock_bit_cell

// ==== core/config_lock_register_bank.sv ====
`timescale 1ns/100ps
// Functional notes
// RL1: timer reset lock makes whole power timer control register read-only to host.
// RL2: wake-control unlock pulse clears timer lock and sleep encoding lock.
// RL3: sleep lock protects sleep state config and six sleep-type registers.
// RL4: five ram lock bits protect ram access controls; ram unlock clears them.
// RL5: write-only bits read back as zero.
// RL6: write-one-to-clear bits clear on one, unchanged on zero.
// RL7: write-one-to-set bits set on one, unchanged on zero.
// RL8: read-specific address reads one register, writes go to another.
// RL9: software writes zero to reserved bits or uses read-modify-write.
// RL10: decode indexes 20h to 2Eh; undefined ones are reserved, read zero.
// RL11: index 20h is read-only fixed family identity.
// RL12: multiplex lock disables writes to config 1 to 5, except named bits.
// RL13: multiplex and gpio locks clear only by selected reset or unlock.
// RL14: multiplex unlock pulse clears multiplex lock.
// RL15: gpio lock protects gpio configuration and itself; gpio unlock clears it.
// RL16: software keeps config one bits 5 to 4 at 01.
// RL17: config one bits 3 to 2 select 0, 2, 6 or 12 wait states.
// RL18: a set lock and its protected bits are read-only to host.
// RL19: standby select picks main or standby power-up reset for clearing locks.
// RL20: locked writes are dropped silently; the cycle completes normally.
// RL21: serial unlock bits act as single-cycle pulses, not stored.
module config_lock_register_bank
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // power-up resets (synchronous pulses from the power controller)
    input wire logic main_power_reset_i,
    input wire logic standby_power_reset_i,
    // host configuration access
    input cfg_lock_pkg::host_req_t host_req_i,
    output logic [7:0] host_rdata_o,
    output logic host_rvalid_o,
    // serial-bus lock control
    input cfg_lock_pkg::serial_lock_control_t serial_lock_control_i,
    // lock status and configuration out
    output logic multiplex_lock_o,
    output logic gpio_config_lock_o,
    output logic power_timer_reset_lock_o,
    output logic sleep_encoding_lock_o,
    output logic [cfg_lock_pkg::RAM_LOCK_BITS-1:0] ram_lock_o,
    output logic [3:0] io_wait_count_o,
    output logic global_device_enable_o,
    output logic host_soft_reset_o
);
    import cfg_lock_pkg::*;

    // ********************************
    // state
    // ********************************
    bank_state_t s_q;
    bank_state_t s_d;
    logic lock_clear;
    logic mux_lock;
    logic gpio_lock;
    logic wr;
    logic mux_set;
    logic gpio_set;
    logic timer_lock;
    logic sleep_lock;
    logic [RAM_LOCK_BITS-1:0] ram_lock;
    logic [7:0] rd_mux;

    assign wr = host_req_i.wr;

    // standby select picks which power-up reset clears every lock [RL19] [RL13]
    assign lock_clear = serial_lock_control_i.standby_lock_select ?
                        standby_power_reset_i : main_power_reset_i;

    assign mux_set = wr && !mux_lock && (host_req_i.idx == IDX_SERVER_CONFIG_ONE)
                     && host_req_i.wdata[CF1_MUX_LOCK_BIT]; // [RL7]
    // gpio lock stays writable under the multiplex lock but not under itself [RL12] [RL15]
    assign gpio_set = wr && !gpio_lock && (host_req_i.idx == IDX_SERVER_CONFIG_ONE)
                      && host_req_i.wdata[CF1_GPIO_LOCK_BIT];

    // ********************************
    // lock cells
    // ********************************
    lock_bit_cell u_mux_lock
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(lock_clear),
        .set_i(mux_set),
        .unlock_i(serial_lock_control_i.multiplex_unlock), // [RL14] [RL21]
        .lock_o(mux_lock)
    );

    lock_bit_cell u_gpio_lock
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(lock_clear),
        .set_i(gpio_set),
        .unlock_i(serial_lock_control_i.gpio_unlock), // [RL15] [RL21]
        .lock_o(gpio_lock)
    );

    assign timer_lock = s_q.power_timer_control[TIMER_LOCK_BIT];
    assign sleep_lock = s_q.sleep_state_config[SLEEP_LOCK_BIT];
    assign ram_lock = s_q.ram_lock_register[RAM_LOCK_BITS-1:0];

    // ********************************
    // read mux
    // ********************************
    always_comb
    begin
        rd_mux = ZERO_BYTE; // reserved indexes read zero [RL10]
        case (host_req_i.idx)
            IDX_FAMILY_IDENTITY: rd_mux = FAMILY_ID_VALUE; // [RL11]
            IDX_SERVER_CONFIG_ONE:
            begin
                rd_mux = s_q.server_config_one;
                rd_mux[CF1_MUX_LOCK_BIT] = mux_lock;
                rd_mux[CF1_GPIO_LOCK_BIT] = gpio_lock;
                rd_mux[CF1_SOFT_RESET_BIT] = 1'b0; // write-only style bit [RL5]
            end
            IDX_SERVER_CONFIG_TWO: rd_mux = s_q.server_config_two;
            IDX_SERVER_CONFIG_THREE: rd_mux = s_q.server_config_three;
            IDX_SERVER_CONFIG_FOUR: rd_mux = s_q.server_config_four;
            IDX_SERVER_CONFIG_FIVE: rd_mux = s_q.server_config_five;
            IDX_SERVER_CONFIG_SIX: rd_mux = s_q.server_config_six;
            IDX_REVISION_IDENTITY: rd_mux = REVISION_ID_VALUE;
            IDX_SERVER_CONFIG_EIGHT: rd_mux = s_q.server_config_eight;
            IDX_CLOCK_GENERATOR_CONFIG: rd_mux = s_q.clock_generator_config;
            IDX_SERIAL_BUS_CONFIG: rd_mux = s_q.serial_bus_config;
            IDX_POWER_TIMER_CONTROL: rd_mux = s_q.power_timer_control;
            IDX_SLEEP_STATE_CONFIG: rd_mux = s_q.sleep_state_config;
            IDX_RAM_LOCK_REGISTER: rd_mux = s_q.ram_lock_register;
            IDX_RAM_ACCESS_CONTROL: rd_mux = s_q.ram_access_control;
            default:
            begin
                if (host_req_i.idx >= IDX_STATE0_SLEEP_TYPE
                    && host_req_i.idx <= IDX_STATE5_SLEEP_TYPE)
                begin
                    rd_mux = s_q.sleep_types[8*(host_req_i.idx - IDX_STATE0_SLEEP_TYPE) +: 8];
                end
            end
        endcase
    end

    // ********************************
    // next state
    // ********************************
    always_comb
    begin
        s_d = s_q;
        s_d.soft_reset_pulse = 1'b0;
        s_d.rvalid = host_req_i.rd || wr; // writes complete too, even when dropped [RL20]
        s_d.rdata = host_req_i.rd ? rd_mux : ZERO_BYTE;
        if (wr)
        begin
            case (host_req_i.idx)
                IDX_SERVER_CONFIG_ONE:
                begin
                    // these bits stay writable under the multiplex lock [RL12]
                    s_d.server_config_one[CF1_ENABLE_BIT] = host_req_i.wdata[CF1_ENABLE_BIT];
                    s_d.soft_reset_pulse = host_req_i.wdata[CF1_SOFT_RESET_BIT];
                    if (!mux_lock)
                    begin
                        s_d.server_config_one[CF1_WAIT_LSB +: 2] =
                            host_req_i.wdata[CF1_WAIT_LSB +: 2]; // [RL17] [RL18]
                    end
                end
                IDX_SERVER_CONFIG_TWO:
                begin
                    if (!mux_lock)
                    begin
                        s_d.server_config_two = host_req_i.wdata; // [RL12]
                    end
                end
                IDX_SERVER_CONFIG_THREE:
                begin
                    if (!mux_lock)
                    begin
                        s_d.server_config_three = host_req_i.wdata; // [RL12]
                    end
                end
                IDX_SERVER_CONFIG_FOUR:
                begin
                    if (!mux_lock)
                    begin
                        s_d.server_config_four = host_req_i.wdata; // [RL12]
                    end
                end
                IDX_SERVER_CONFIG_FIVE:
                begin
                    if (!mux_lock)
                    begin
                        s_d.server_config_five = host_req_i.wdata; // [RL12]
                    end
                end
                IDX_SERVER_CONFIG_SIX: s_d.server_config_six = host_req_i.wdata;
                IDX_SERVER_CONFIG_EIGHT: s_d.server_config_eight = host_req_i.wdata;
                IDX_CLOCK_GENERATOR_CONFIG: s_d.clock_generator_config = host_req_i.wdata;
                IDX_SERIAL_BUS_CONFIG: s_d.serial_bus_config = host_req_i.wdata;
                IDX_POWER_TIMER_CONTROL:
                begin
                    // whole register frozen under its own lock [RL1] [RL18]
                    if (!timer_lock)
                    begin
                        s_d.power_timer_control = host_req_i.wdata;
                    end
                end
                IDX_SLEEP_STATE_CONFIG:
                begin
                    if (!sleep_lock)
                    begin
                        s_d.sleep_state_config = host_req_i.wdata; // [RL3]
                    end
                end
                IDX_RAM_LOCK_REGISTER:
                begin
                    // ram lock bits are sticky: a one sets, a zero leaves [RL7] [RL4]
                    s_d.ram_lock_register[RAM_LOCK_BITS-1:0] =
                        ram_lock | host_req_i.wdata[RAM_LOCK_BITS-1:0];
                    // release status: a one clears it, a zero leaves it [RL6]
                    if (host_req_i.wdata[RAM_UNLOCK_SEEN_BIT])
                    begin
                        s_d.ram_lock_register[RAM_UNLOCK_SEEN_BIT] = 1'b0;
                    end
                end
                IDX_RAM_ACCESS_CONTROL:
                begin
                    // each access control bit is held by its matching lock [RL4]
                    for (int i = 0; i < RAM_LOCK_BITS; i++)
                    begin
                        if (!ram_lock[i])
                        begin
                            s_d.ram_access_control[i] = host_req_i.wdata[i];
                        end
                    end
                end
                default:
                begin
                    if (!sleep_lock && host_req_i.idx >= IDX_STATE0_SLEEP_TYPE
                        && host_req_i.idx <= IDX_STATE5_SLEEP_TYPE)
                    begin
                        s_d.sleep_types[8*(host_req_i.idx - IDX_STATE0_SLEEP_TYPE) +: 8] =
                            host_req_i.wdata; // [RL3]
                    end
                end
            endcase
        end
        // unlock pulses and the selected power-up reset release the wake/ram locks
        if (serial_lock_control_i.wake_control_unlock || lock_clear)
        begin
            s_d.power_timer_control[TIMER_LOCK_BIT] = 1'b0; // [RL2] [RL21]
            s_d.sleep_state_config[SLEEP_LOCK_BIT] = 1'b0; // [RL2]
        end
        if (serial_lock_control_i.ram_unlock || lock_clear)
        begin
            s_d.ram_lock_register[RAM_LOCK_BITS-1:0] = '0; // [RL4] [RL21]
        end
        // tells the host a serial release happened; the set beats a same-cycle clear
        if (serial_lock_control_i.ram_unlock)
        begin
            s_d.ram_lock_register[RAM_UNLOCK_SEEN_BIT] = 1'b1; // [RL6]
        end
        // reserved field pinned to its required value
        s_d.server_config_one[5:4] = CF1_RSVD_VALUE;
        s_d.server_config_one[7:6] = 2'h0;
        s_d.server_config_one[CF1_SOFT_RESET_BIT] = 1'b0;
        case (s_d.server_config_one[CF1_WAIT_LSB +: 2]) // [RL17]
            2'h0: s_d.wait_count = WAIT_CNT_NONE;
            2'h1: s_d.wait_count = WAIT_CNT_TWO;
            2'h2: s_d.wait_count = WAIT_CNT_SIX;
            default: s_d.wait_count = WAIT_CNT_TWELVE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.server_config_one <= CF1_RESET;
            s_q.server_config_two <= CF2_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign host_rdata_o = s_q.rdata;
    assign host_rvalid_o = s_q.rvalid;
    assign multiplex_lock_o = mux_lock;
    assign gpio_config_lock_o = gpio_lock;
    assign power_timer_reset_lock_o = timer_lock;
    assign sleep_encoding_lock_o = sleep_lock;
    assign ram_lock_o = ram_lock;
    assign io_wait_count_o = s_q.wait_count;
    assign global_device_enable_o = s_q.server_config_one[CF1_ENABLE_BIT];
    assign host_soft_reset_o = s_q.soft_reset_pulse;

endmodule : config_lock_register_bank

// ==== dv/cfg_lock_props.sv ====
`timescale 1ns/100ps
// ****************************************
// lock and access checker for the bank
// ****************************************
module cfg_lock_props
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs
    input wire logic main_power_reset_i,
    input wire logic standby_power_reset_i,
    input wire cfg_lock_pkg::host_req_t host_req_i,
    input wire cfg_lock_pkg::serial_lock_control_t serial_lock_control_i,
    // outputs
    input wire logic [7:0] host_rdata_o,
    input wire logic host_rvalid_o,
    input wire logic multiplex_lock_o,
    input wire logic gpio_config_lock_o,
    input wire logic power_timer_reset_lock_o,
    input wire logic sleep_encoding_lock_o,
    input wire logic [cfg_lock_pkg::RAM_LOCK_BITS-1:0] ram_lock_o,
    input wire logic [3:0] io_wait_count_o,
    input wire logic global_device_enable_o,
    input wire logic host_soft_reset_o
);
    import cfg_lock_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_cf1;
    assign rd_cf1 = host_req_i.rd && host_req_i.idx == IDX_SERVER_CONFIG_ONE;

    property p_answer;
        host_req_i.wr || host_req_i.rd |=> host_rvalid_o;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer to access");
    property p_family;
        host_req_i.rd && host_req_i.idx == IDX_FAMILY_IDENTITY |=> host_rdata_o == FAMILY_ID_VALUE;
    endproperty
    a_family: assert property (p_family) else $error("family id wrong");
    property p_reserved;
        host_req_i.rd && host_req_i.idx > IDX_SERIAL_BUS_CONFIG
            && host_req_i.idx <= IDX_DECODE_LAST |=> host_rdata_o == ZERO_BYTE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved index not zero");
    property p_wo_zero;
        rd_cf1 |=> !host_rdata_o[CF1_SOFT_RESET_BIT];
    endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("soft reset bit read one");
    property p_mux_unlock;
        serial_lock_control_i.multiplex_unlock |=> !multiplex_lock_o;
    endproperty
    a_mux_unlock: assert property (p_mux_unlock) else $error("mux lock kept");
    property p_gpio_unlock;
        serial_lock_control_i.gpio_unlock |=> !gpio_config_lock_o;
    endproperty
    a_gpio_unlock: assert property (p_gpio_unlock) else $error("gpio lock kept");
    property p_wake_unlock;
        serial_lock_control_i.wake_control_unlock |=>
            !power_timer_reset_lock_o && !sleep_encoding_lock_o;
    endproperty
    a_wake_unlock: assert property (p_wake_unlock) else $error("wake locks kept");
    property p_ram_unlock;
        serial_lock_control_i.ram_unlock |=> ram_lock_o == '0;
    endproperty
    a_ram_unlock: assert property (p_ram_unlock) else $error("ram locks kept");
    property p_mux_sticky;
        multiplex_lock_o && !serial_lock_control_i.multiplex_unlock
            && !main_power_reset_i && !standby_power_reset_i |=> multiplex_lock_o;
    endproperty
    a_mux_sticky: assert property (p_mux_sticky) else $error("mux lock dropped");
    property p_wait_frozen;
        multiplex_lock_o [*3] |-> $stable(io_wait_count_o);
    endproperty
    a_wait_frozen: assert property (p_wait_frozen) else $error("wait changed");

    c_mux_release: cover property (multiplex_lock_o ##1 !multiplex_lock_o);
    c_gpio_set: cover property (!gpio_config_lock_o ##1 gpio_config_lock_o);
    c_ram_release: cover property (ram_lock_o != '0 ##1 ram_lock_o == '0);
endmodule : cfg_lock_props

bind config_lock_register_bank cfg_lock_props u_props (.*);

// ==== dv/lock_ctrl_model.sv ====
`timescale 1ns/100ps
// ****************************************
// serial-bus controller side of the locks
// ****************************************
module lock_ctrl_model
(
    // clock
    input wire logic clk_i,
    // requests: wake, ram, mux, gpio
    input wire logic [3:0] unlock_req_i,
    input wire logic standby_sel_i,
    // toward the bank
    output cfg_lock_pkg::serial_lock_control_t serial_lock_control_o
);
    import cfg_lock_pkg::*;
    logic [3:0] req_q;
    // a held request still gives one pulse; the unlock bit never stays set
    always_ff @(posedge clk_i)
    begin
        req_q <= unlock_req_i;
        serial_lock_control_o <= {unlock_req_i & ~req_q, standby_sel_i};
    end
endmodule : lock_ctrl_model

// ==== dv/config_lock_register_bank_tb.sv ====
`timescale 1ns/100ps
module config_lock_register_bank_tb;
    import cfg_lock_pkg::*;
    localparam logic [7:0] CF1 = IDX_SERVER_CONFIG_ONE;
    localparam logic [7:0] CF2 = IDX_SERVER_CONFIG_TWO;
    localparam logic [7:0] PTC = IDX_POWER_TIMER_CONTROL;
    localparam logic [7:0] SSC = IDX_SLEEP_STATE_CONFIG;
    localparam logic [7:0] RLOCK = IDX_RAM_LOCK_REGISTER;
    localparam logic [7:0] RAC = IDX_RAM_ACCESS_CONTROL;
    logic clk_i, rst_n_i, mpr, spr, usel, rvalid, mlk, glk, tlk, slk, en, srst;
    logic [3:0] ureq, wcnt;
    logic [7:0] rdata;
    logic [RAM_LOCK_BITS-1:0] rlk;
    host_req_t req;
    serial_lock_control_t slc;
    int err_total, check_count;
    logic [3:0] wtab [4] = '{WAIT_CNT_NONE, WAIT_CNT_TWO, WAIT_CNT_SIX, WAIT_CNT_TWELVE};

    config_lock_register_bank uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .main_power_reset_i(mpr), .standby_power_reset_i(spr), .host_req_i(req),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid), .serial_lock_control_i(slc),
        .multiplex_lock_o(mlk), .gpio_config_lock_o(glk), .power_timer_reset_lock_o(tlk),
        .sleep_encoding_lock_o(slk), .ram_lock_o(rlk), .io_wait_count_o(wcnt),
        .global_device_enable_o(en), .host_soft_reset_o(srst));
    lock_ctrl_model u_ctrl (.clk_i(clk_i), .unlock_req_i(ureq), .standby_sel_i(usel),
        .serial_lock_control_o(slc));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // writes expect zero read data, reads the register value
    task automatic acc(input logic w, input logic [7:0] idx, dat, exp);
        @(posedge clk_i);
        req <= {w, ~w, idx, dat};
        @(posedge clk_i);
        req <= '0;
        #1;
        chk("rvalid", 8'h01, {7'h0, rvalid});
        chk("rdata", exp, rdata);
    endtask : acc

    task automatic unl(input logic [3:0] m);
        @(posedge clk_i);
        ureq <= m;
        @(posedge clk_i);
        ureq <= 4'h0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : unl

    task automatic pwr(input logic m, input logic s);
        @(posedge clk_i);
        mpr <= m;
        spr <= s;
        @(posedge clk_i);
        mpr <= 1'b0;
        spr <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : pwr

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    initial
    begin
        #400000;
        err_total++;
        final_report;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rst_n_i, mpr, spr, usel, ureq, req} = '0;
        mpr = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        mpr <= 1'b0;
        acc(0, IDX_FAMILY_IDENTITY, 8'h00, FAMILY_ID_VALUE);
        acc(1, IDX_FAMILY_IDENTITY, 8'hFF, 8'h00);
        acc(0, IDX_FAMILY_IDENTITY, 8'h00, FAMILY_ID_VALUE);
        acc(0, CF1, 8'h00, CF1_RESET);
        for (int i = 8'h2B; i <= 8'h2E; i++) acc(0, 8'(i), 8'h00, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            acc(1, CF1, 8'h13 | 8'(i << 2), 8'h00);
            acc(0, CF1, 8'h00, 8'h11 | 8'(i << 2));
            chk("wait", {4'h0, wtab[i]}, {4'h0, wcnt});
        end
        acc(1, CF1, 8'h10, 8'h00);
        chk("enable", 8'h00, {7'h0, en});
        chk("soft reset", 8'h00, {7'h0, srst});
        acc(1, CF1, 8'h95, 8'h00);
        acc(1, CF1, 8'h1B, 8'h00);
        chk("soft reset", 8'h01, {7'h0, srst});
        acc(0, CF1, 8'h00, 8'h95);
        chk("wait", {4'h0, WAIT_CNT_TWO}, {4'h0, wcnt});
        acc(1, CF2, 8'hFF, 8'h00);
        acc(0, CF2, 8'h00, CF2_RESET);
        acc(1, CF1, 8'h51, 8'h00);
        acc(0, CF1, 8'h00, 8'hD5);
        unl(4'h2);
        chk("mux lock", 8'h00, {7'h0, mlk});
        chk("gpio lock", 8'h01, {7'h0, glk});
        acc(1, CF2, 8'hFF, 8'h00);
        acc(0, CF2, 8'h00, 8'hFF);
        unl(4'h1);
        chk("gpio lock", 8'h00, {7'h0, glk});
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk_i);
            usel <= s[0];
            acc(1, CF1, 8'hD1, 8'h00);
            pwr(s[0], !s[0]);
            chk("mux lock", 8'h01, {7'h0, mlk});
            pwr(!s[0], s[0]);
            chk("locks", 8'h00, {6'h0, mlk, glk});
        end
        acc(1, PTC, 8'h81, 8'h00);
        acc(1, PTC, 8'h02, 8'h00);
        acc(0, PTC, 8'h00, 8'h81);
        for (int i = 0; i < 6; i++) acc(1, IDX_STATE0_SLEEP_TYPE + 8'(i), 8'(i + 1), 8'h00);
        acc(1, SSC, 8'h80, 8'h00);
        acc(1, SSC, 8'h00, 8'h00);
        acc(0, SSC, 8'h00, 8'h80);
        for (int i = 0; i < 6; i++)
        begin
            acc(1, IDX_STATE0_SLEEP_TYPE + 8'(i), 8'hFF, 8'h00);
            acc(0, IDX_STATE0_SLEEP_TYPE + 8'(i), 8'h00, 8'(i + 1));
        end
        unl(4'h8);
        chk("wake locks", 8'h00, {6'h0, tlk, slk});
        acc(1, PTC, 8'h00, 8'h00);
        acc(0, PTC, 8'h00, 8'h00);
        acc(1, RAC, 8'h1F, 8'h00);
        acc(1, RLOCK, 8'h05, 8'h00);
        acc(1, RLOCK, 8'h00, 8'h00);
        acc(0, RLOCK, 8'h00, 8'h05);
        acc(1, RAC, 8'h00, 8'h00);
        acc(0, RAC, 8'h00, 8'h05);
        unl(4'h4);
        chk("ram lock", 8'h00, {3'h0, rlk});
        acc(0, RLOCK, 8'h00, 8'h80);
        acc(1, RLOCK, 8'h00, 8'h00);
        acc(0, RLOCK, 8'h00, 8'h80);
        acc(1, RLOCK, 8'h80, 8'h00);
        acc(0, RLOCK, 8'h00, 8'h00);
        acc(1, RAC, 8'h00, 8'h00);
        acc(0, RAC, 8'h00, 8'h00);
        final_report;
    end
endmodule : config_lock_register_bank_tb
